/* File: logic/cpo_pkg.sv */
package cpo_pkg;
    localparam logic [7:0] REG_ADDR      = 8'h32;
    localparam logic [7:0] REG_RESET_VAL = 8'hb7;
    localparam int BIT_EXT_LIMIT    = 7;
    localparam int BIT_MON_DIR      = 6;
    localparam int BIT_LS_OC_RANGE  = 5;
    localparam int BIT_IN_OC_RANGE  = 4;
    localparam int BIT_IN_OC_EN     = 3;
    localparam int BIT_IN_OC_RATIO  = 2;
    localparam int BIT_DIS_OC_EN    = 1;
    localparam int BIT_DIS_OC_RATIO = 0;
    localparam int LS_OC_LOW_MV   = 150;
    localparam int LS_OC_HIGH_MV  = 260;
    localparam int IN_OC_LOW_MV   = 300;
    localparam int IN_OC_HIGH_MV  = 450;
    localparam int UV_LOW_MV      = 150;
    localparam int UV_HIGH_MV     = 300;
    localparam int IN_RATIO_LOW_X100  = 133;
    localparam int IN_RATIO_HIGH_X100 = 200;
    localparam int DIS_RATIO_LOW   = 2;
    localparam int DIS_RATIO_HIGH  = 3;
    localparam int CLK_MHZ         = 100;
    localparam int BLANK_US        = 250;
    localparam int BLANK_CYCLES    = BLANK_US * CLK_MHZ;
    localparam int SW_DIV_DEFAULT  = 167;
    localparam int MV_W            = 10;
    localparam int LIM_W           = 8;
    localparam int CNT_W           = 16;
endpackage

/* File: logic/cpo_persist.sv */
`timescale 1ns/1ps
module cpo_persist
#(
    parameter int LIMIT = 2
)
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic cond,
    output logic      fire
);
    import cpo_pkg::*;

    localparam logic [CNT_W-1:0] LIM = CNT_W'(LIMIT);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic             next_fire;

    // A limit the counter cannot reach would never fire
    if (LIMIT < 1 || LIMIT >= (1 << CNT_W))
    begin
        $error("cpo_persist: LIMIT out of range");
    end

    always_comb
    begin
        next_cnt  = cnt;
        next_fire = 1'b0;
        if (!cond)
            next_cnt = '0;
        else if (cnt < LIM)
            next_cnt = cnt + 1'b1;
        if (cond && cnt >= LIM)
            next_fire = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            cnt  <= '0;
            fire <= 1'b0;
        end
        else
        begin
            cnt  <= next_cnt;
            fire <= next_fire;
        end
    end
endmodule

/* File: logic/cpo_top.sv */
`timescale 1ns/1ps
// Summary of operation
// [R1] Register at 0x32, resets to 0xb7
// [R2] Bit7 picks host limit or smaller
// [R3] Bit6 selects discharge or charge monitor
// [R4] Bit5 sets low-side threshold 150/260 mV
// [R5] Bit4 sets input threshold, halved-ish under UV
// [R6] Overcurrent for a whole switching cycle latches converter off
// [R7] Host toggles highz bit 0-1-0 to restart
// [R8] Input overcurrent beyond 250us disables converter
// [R9] Bit2 scales input threshold 1.33 or 2
// [R10] Discharge overcurrent when enabled disables converter
// [R11] Bit0 scales discharge threshold 2 or 3
// [R12] Register-reset command restores reset value
// [R13] Readback exact and updated with the register; outputs follow one cycle later
module cpo_top
#(
    parameter int BLANK_CNT = cpo_pkg::BLANK_CYCLES,
    parameter int SW_DIV    = cpo_pkg::SW_DIV_DEFAULT
)
(
    input  wire logic                      core_clk,
    input  wire logic                      nrst,
    input  wire logic [7:0]                reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_wr,
    output logic      [7:0]                reg_rdata,
    input  wire logic                      reg_reset_cmd,
    input  wire logic                      converter_highz_control,
    input  wire logic [cpo_pkg::LIM_W-1:0] limit_setting_pin,
    input  wire logic [cpo_pkg::LIM_W-1:0] host_input_limit,
    output logic      [cpo_pkg::LIM_W-1:0] effective_input_limit,
    output logic                           monitor_direction_select,
    output logic      [cpo_pkg::MV_W-1:0]  lowside_oc_thresh_mv,
    output logic      [cpo_pkg::MV_W-1:0]  input_oc_thresh_mv,
    output logic      [7:0]                input_oc_ratio_x100,
    output logic      [1:0]                discharge_oc_ratio,
    input  wire logic                      system_undervoltage,
    input  wire logic                      lowside_oc_raw,
    input  wire logic                      input_sense_oc_raw,
    input  wire logic                      input_overcurrent_raw,
    input  wire logic                      discharge_overcurrent_raw,
    output logic                           converter_off
);
    import cpo_pkg::*;

    // The divider is 16 bits; a one-cycle period leaves no fault window
    if (SW_DIV < 2 || SW_DIV > 65536 || BLANK_CNT < 1)
    begin
        $error("cpo_top: bad parameters");
    end

    logic [7:0]       protection_option_ctrl;
    logic [7:0]       next_protection_option_ctrl;
    logic [5:0]       s1, s2, s3, stab, next_stab;
    logic [LIM_W-1:0] pin_s1, pin_s2, pin_s3, pin_stab, next_pin_stab;
    logic [15:0] div_cnt;
    logic [15:0] next_div_cnt;
    logic        sw_tick;
    logic        sw_oc_seen;
    logic        next_sw_oc_seen;
    logic        latched;
    logic        next_latched;
    logic        hz_prev;
    logic        hz_armed;
    logic        next_hz_armed;
    logic        input_overcurrent_fire;
    logic [LIM_W-1:0] next_eff;
    logic [MV_W-1:0]  next_ls_mv;
    logic [MV_W-1:0]  next_in_mv;
    logic        next_off;
    logic        ls_oc, in_oc, ac_sync, ac_oc, dis_oc, uv, hz;

    // Pins are asynchronous: three flops, act when 2nd and 3rd agree
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            s1       <= '0;
            s2       <= '0;
            s3       <= '0;
            stab     <= '0;
            pin_s1   <= '0;
            pin_s2   <= '0;
            pin_s3   <= '0;
            pin_stab <= '0;
        end
        else
        begin
            s1       <= {input_overcurrent_raw, converter_highz_control, system_undervoltage,
                         lowside_oc_raw, input_sense_oc_raw, discharge_overcurrent_raw};
            s2       <= s1;
            s3       <= s2;
            stab     <= next_stab;
            pin_s1   <= limit_setting_pin;
            pin_s2   <= pin_s1;
            pin_s3   <= pin_s2;
            pin_stab <= next_pin_stab;
        end
    end

    // Keep the last agreed level while the 2nd and 3rd flops differ
    always_comb
    begin
        for (int i = 0; i < $bits(stab); i++)
            next_stab[i] = (s2[i] == s3[i]) ? s3[i] : stab[i];
        for (int i = 0; i < LIM_W; i++)
            next_pin_stab[i] = (pin_s2[i] == pin_s3[i]) ? pin_s3[i] : pin_stab[i];
    end
    assign {ac_sync, hz, uv, ls_oc, in_oc, dis_oc} = stab;
    assign ac_oc = ac_sync & protection_option_ctrl[BIT_IN_OC_EN];

    // Register file: single location, exact readback
    always_comb
    begin
        next_protection_option_ctrl = protection_option_ctrl;
        if (reg_reset_cmd)
            next_protection_option_ctrl = REG_RESET_VAL;       // [R12]
        else if (reg_wr && reg_addr == REG_ADDR)
            next_protection_option_ctrl = reg_wdata;           // [R13]
    end

    // Switching-cycle tick from divider
    always_comb
    begin
        next_div_cnt = (div_cnt == 16'(SW_DIV - 1)) ? 16'h0000 : div_cnt + 16'h0001;
    end
    assign sw_tick = (div_cnt == 16'(SW_DIV - 1));

    // Fault must hold across a whole switching period to latch
    always_comb
    begin
        next_sw_oc_seen = sw_tick ? 1'b1 : (sw_oc_seen & (ls_oc | in_oc));
    end

    cpo_persist #(
        .LIMIT (BLANK_CNT)
    ) u_blank (
        .clk   (core_clk),
        .nrst  (nrst),
        .cond  (ac_oc),
        .fire  (input_overcurrent_fire)                                     // [R8]
    );

    // Latch clears only on a 0->1->0 highz sequence
    always_comb
    begin
        next_hz_armed = hz_armed;
        if (hz && !hz_prev)
            next_hz_armed = 1'b1;                              // [R7]
        next_latched = latched;
        if (hz_armed && hz_prev && !hz)
        begin
            next_latched  = 1'b0;
            next_hz_armed = 1'b0;
        end
        if (sw_tick && sw_oc_seen && (ls_oc | in_oc))
            next_latched = 1'b1;                               // [R6]
    end

    always_comb
    begin
        next_eff = host_input_limit;                           // [R2]
        if (protection_option_ctrl[BIT_EXT_LIMIT] && pin_stab < host_input_limit)
            next_eff = pin_stab;
        next_ls_mv = protection_option_ctrl[BIT_LS_OC_RANGE] ? MV_W'(LS_OC_HIGH_MV)
                                                             : MV_W'(LS_OC_LOW_MV); // [R4]
        if (uv)
            next_in_mv = protection_option_ctrl[BIT_IN_OC_RANGE] ? MV_W'(UV_HIGH_MV)
                                                                 : MV_W'(UV_LOW_MV); // [R5]
        else
            next_in_mv = protection_option_ctrl[BIT_IN_OC_RANGE] ? MV_W'(IN_OC_HIGH_MV)
                                                                 : MV_W'(IN_OC_LOW_MV);
        next_off = next_latched | input_overcurrent_fire
                 | (protection_option_ctrl[BIT_DIS_OC_EN] & dis_oc); // [R10]
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            protection_option_ctrl <= REG_RESET_VAL;           // [R1]
            div_cnt    <= '0;
            sw_oc_seen <= 1'b0;
            latched    <= 1'b0;
            hz_prev    <= 1'b0;
            hz_armed   <= 1'b0;
            reg_rdata  <= REG_RESET_VAL;
            effective_input_limit    <= '0;
            monitor_direction_select <= 1'b0;
            lowside_oc_thresh_mv     <= MV_W'(LS_OC_HIGH_MV);
            input_oc_thresh_mv       <= MV_W'(IN_OC_HIGH_MV);
            input_oc_ratio_x100      <= 8'(IN_RATIO_HIGH_X100);
            discharge_oc_ratio       <= 2'(DIS_RATIO_HIGH);
            converter_off            <= 1'b0;
        end
        else
        begin
            protection_option_ctrl <= next_protection_option_ctrl;
            div_cnt    <= next_div_cnt;
            sw_oc_seen <= next_sw_oc_seen;
            latched    <= next_latched;
            hz_prev    <= hz;
            hz_armed   <= next_hz_armed;
            reg_rdata  <= next_protection_option_ctrl;         // [R13]
            effective_input_limit    <= next_eff;
            monitor_direction_select <= protection_option_ctrl[BIT_MON_DIR]; // [R3]
            lowside_oc_thresh_mv     <= next_ls_mv;
            input_oc_thresh_mv       <= next_in_mv;
            input_oc_ratio_x100      <= protection_option_ctrl[BIT_IN_OC_RATIO]
                                        ? 8'(IN_RATIO_HIGH_X100) : 8'(IN_RATIO_LOW_X100); // [R9]
            discharge_oc_ratio       <= protection_option_ctrl[BIT_DIS_OC_RATIO]
                                        ? 2'(DIS_RATIO_HIGH) : 2'(DIS_RATIO_LOW);   // [R11]
            converter_off            <= next_off;
        end
    end

    property p_reset_val;
        @(posedge core_clk) disable iff (!nrst)
        reg_reset_cmd |=> protection_option_ctrl == REG_RESET_VAL;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("reset cmd not applied"); // [R12]

    property p_readback;
        @(posedge core_clk) disable iff (!nrst)
        (reg_wr && reg_addr == REG_ADDR && !reg_reset_cmd) |=> reg_rdata == $past(reg_wdata);
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch"); // [R13]

    property p_limit;
        @(posedge core_clk) disable iff (!nrst)
        !protection_option_ctrl[BIT_EXT_LIMIT]
        |=> effective_input_limit == $past(host_input_limit);
    endproperty
    a_limit: assert property (p_limit) else $error("host limit not used"); // [R2]

    property p_mon;
        @(posedge core_clk) disable iff (!nrst)
        ##1 monitor_direction_select == $past(protection_option_ctrl[BIT_MON_DIR]);
    endproperty
    a_mon: assert property (p_mon) else $error("monitor select wrong"); // [R3]

    property p_ls;
        @(posedge core_clk) disable iff (!nrst)
        protection_option_ctrl[BIT_LS_OC_RANGE]
        |=> lowside_oc_thresh_mv == MV_W'(LS_OC_HIGH_MV);
    endproperty
    a_ls: assert property (p_ls) else $error("lowside threshold wrong"); // [R4]

    property p_in_uv;
        @(posedge core_clk) disable iff (!nrst)
        (uv && !protection_option_ctrl[BIT_IN_OC_RANGE])
        |=> input_oc_thresh_mv == MV_W'(UV_LOW_MV);
    endproperty
    a_in_uv: assert property (p_in_uv) else $error("input threshold under uv wrong"); // [R5]

    property p_latch_holds;
        @(posedge core_clk) disable iff (!nrst)
        (latched && !hz_armed) |=> latched;
    endproperty
    a_latch_holds: assert property (p_latch_holds) else $error("latch dropped"); // [R6]

    property p_off;
        @(posedge core_clk) disable iff (!nrst)
        latched |-> converter_off;
    endproperty
    a_off: assert property (p_off) else $error("latched but not off"); // [R6]

    property p_doc;
        @(posedge core_clk) disable iff (!nrst)
        (protection_option_ctrl[BIT_DIS_OC_EN] && dis_oc) |=> converter_off;
    endproperty
    a_doc: assert property (p_doc) else $error("discharge oc ignored"); // [R10]

    property p_ratio;
        @(posedge core_clk) disable iff (!nrst)
        !protection_option_ctrl[BIT_DIS_OC_RATIO]
        |=> discharge_oc_ratio == 2'(DIS_RATIO_LOW);
    endproperty
    a_ratio: assert property (p_ratio) else $error("discharge ratio wrong"); // [R11]

    c_latch:  cover property (@(posedge core_clk) disable iff (!nrst) $rose(latched));
    c_clear:  cover property (@(posedge core_clk) disable iff (!nrst) $fell(latched));
    c_input_overcurrent:   cover property (@(posedge core_clk) disable iff (!nrst) input_overcurrent_fire);
endmodule

/* File: sim/cpo_host_model.sv */
`timescale 1ns/1ps
module cpo_host_model
    import cpo_pkg::*;
(
    input  wire logic       core_clk,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            converter_highz_control
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h5a;
        reg_wr = 1'b0;
        converter_highz_control = 1'b0;
    end

    // Called just after a falling edge; strobe lasts one cycle
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        // Data is not held after the strobe, so nothing may rely on it
        reg_wdata = ~d;
    endtask

    // Long enough on each level to pass the three-flop synchroniser
    task automatic toggle_highz();
        converter_highz_control = 1'b1;
        repeat (6) @(negedge core_clk);
        converter_highz_control = 1'b0;
        repeat (6) @(negedge core_clk);
    endtask
endmodule

/* File: sim/cpo_top_tb_top.sv */
`timescale 1ns/1ps
module cpo_top_tb_top
    import cpo_pkg::*;
;
    logic       core_clk;
    logic       nrst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic [7:0] reg_rdata;
    logic       reg_reset_cmd;
    logic       hiz;
    logic [7:0] pin;
    logic [7:0] host;
    logic [7:0] lim;
    logic       mon;
    logic [9:0] ls_mv;
    logic [9:0] in_mv;
    logic [7:0] in_ratio;
    logic [1:0] dis_ratio;
    logic       uv;
    logic [1:0] sw_raw;
    logic       ioc;
    logic       doc;
    logic       off;
    int         failures;
    int         cmp_count;
    int         cycles;
    logic [7:0] vals [5] = '{8'h00, 8'hff, 8'h6a, 8'h95, 8'h48};

    cpo_top #(.BLANK_CNT(20), .SW_DIV(8)) i_cpo_top (
        .core_clk                  (core_clk),
        .nrst                      (nrst),
        .reg_addr                  (reg_addr),
        .reg_wdata                 (reg_wdata),
        .reg_wr                    (reg_wr),
        .reg_rdata                 (reg_rdata),
        .reg_reset_cmd             (reg_reset_cmd),
        .converter_highz_control   (hiz),
        .limit_setting_pin         (pin),
        .host_input_limit          (host),
        .effective_input_limit     (lim),
        .monitor_direction_select  (mon),
        .lowside_oc_thresh_mv      (ls_mv),
        .input_oc_thresh_mv        (in_mv),
        .input_oc_ratio_x100       (in_ratio),
        .discharge_oc_ratio        (dis_ratio),
        .system_undervoltage       (uv),
        .lowside_oc_raw            (sw_raw[0]),
        .input_sense_oc_raw        (sw_raw[1]),
        .input_overcurrent_raw     (ioc),
        .discharge_overcurrent_raw (doc),
        .converter_off             (off)
    );

    cpo_host_model i_cpo_host_model (
        .core_clk                (core_clk),
        .reg_addr                (reg_addr),
        .reg_wdata               (reg_wdata),
        .reg_wr                  (reg_wr),
        .converter_highz_control (hiz)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            summarize();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_cfg(input logic [7:0] v);
        int t;
        t = v[4] ? (uv ? UV_HIGH_MV : IN_OC_HIGH_MV) : (uv ? UV_LOW_MV : IN_OC_LOW_MV);
        check(16'(reg_rdata), 16'(v));
        check(16'(lim), 16'(v[7] && pin < host ? pin : host));
        check(16'(mon), 16'(v[6]));
        check(16'(ls_mv), 16'(v[5] ? LS_OC_HIGH_MV : LS_OC_LOW_MV));
        check(16'(in_mv), 16'(t));
        check(16'(in_ratio), 16'(v[2] ? IN_RATIO_HIGH_X100 : IN_RATIO_LOW_X100));
        check(16'(dis_ratio), 16'(v[0] ? DIS_RATIO_HIGH : DIS_RATIO_LOW));
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_cpo_host_model.write_reg(a, d);
        repeat (3) @(negedge core_clk);
    endtask

    task automatic wait_off(input logic exp, input int lim_n);
        int n;
        n = 0;
        while (off !== exp && n < lim_n)
        begin
            @(negedge core_clk);
            n++;
        end
        check(16'(off), 16'(exp));
    endtask

    initial
    begin
        nrst = 1'b0;
        reg_reset_cmd = 1'b0;
        pin = 8'h40;
        host = 8'h90;
        uv = 1'b0;
        sw_raw = 2'b00;
        ioc = 1'b0;
        doc = 1'b0;
        repeat (4) @(negedge core_clk);
        nrst = 1'b1;
        // The limit pin passes three flops and an agree stage before the output
        repeat (6) @(negedge core_clk);
        check_cfg(REG_RESET_VAL);
        // Second pass swaps the limits so both sides of the minimum are seen
        for (int u = 0; u < 2; u++)
        begin
            uv = u[0];
            pin = u[0] ? 8'h90 : 8'h40;
            host = u[0] ? 8'h40 : 8'h90;
            // Let the synchronised pins settle before any expectation uses them
            repeat (6) @(negedge core_clk);
            foreach (vals[i])
            begin
                wr(REG_ADDR, vals[i]);
                check_cfg(vals[i]);
            end
        end
        wr(8'h31, 8'h00);
        wr(8'h33, 8'h00);
        check(16'(reg_rdata), 16'(8'h48));
        // A write in the reset-command cycle is dropped
        fork
            wr(REG_ADDR, 8'h00);
            begin
                reg_reset_cmd = 1'b1;
                @(negedge core_clk);
                reg_reset_cmd = 1'b0;
            end
        join
        check_cfg(REG_RESET_VAL);
        for (int k = 0; k < 2; k++)
        begin
            sw_raw[k] = 1'b1;
            repeat (3) @(negedge core_clk);
            sw_raw[k] = 1'b0;
            repeat (12) @(negedge core_clk);
            check(16'(off), 16'(1'b0));
            sw_raw[k] = 1'b1;
            wait_off(1'b1, 40);
            sw_raw[k] = 1'b0;
            repeat (12) @(negedge core_clk);
            check(16'(off), 16'(1'b1));
            i_cpo_host_model.toggle_highz();
            check(16'(off), 16'(1'b0));
        end
        wr(REG_ADDR, 8'h08);
        ioc = 1'b1;
        repeat (10) @(negedge core_clk);
        check(16'(off), 16'(1'b0));
        ioc = 1'b0;
        repeat (5) @(negedge core_clk);
        ioc = 1'b1;
        wait_off(1'b1, 40);
        ioc = 1'b0;
        wait_off(1'b0, 10);
        wr(REG_ADDR, 8'h02);
        ioc = 1'b1;
        repeat (40) @(negedge core_clk);
        check(16'(off), 16'(1'b0));
        ioc = 1'b0;
        doc = 1'b1;
        wait_off(1'b1, 10);
        doc = 1'b0;
        wait_off(1'b0, 10);
        wr(REG_ADDR, 8'h00);
        doc = 1'b1;
        repeat (10) @(negedge core_clk);
        check(16'(off), 16'(1'b0));
        doc = 1'b0;
        summarize();
    end
endmodule
